// >>> testbench.sv
`include "tprc_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic write_strobe = 1'b0;
   logic continuous_write = 1'b1;
   logic hard_ip_pcie_mode = 1'b0;
   logic pll_index_first = 1'b0;
   logic [2:0] mode_sel = 3'h0;
   logic [1:0] channel_index = 2'h0;
   logic [1:0] divider_select = 2'h0;
   logic [15:0] mif_data, xcvr_word_ff;
   logic [5:0] mif_addr_ff, xcvr_addr_ff;
   logic [1:0] xcvr_channel_ff, pll_powerdown_ff, pll_ref_index_ff, divider_readback_ff;
   logic [7:0] tx_divider_ff, rx_divider_ff;
   logic xcvr_write_ff, busy_ff, done_ff;
   logic [7:0] exp_tx = 8'h00;
   int n_fail = 0;
   int n_tests = 0;
   tprc_top dut_u (.clock(clock), .rstn(rstn), .mode_sel(mode_sel), .channel_index(channel_index),
      .write_strobe(write_strobe), .continuous_write(continuous_write), .divider_select(divider_select),
      .hard_ip_pcie_mode(hard_ip_pcie_mode), .pll_index_first(pll_index_first), .mif_data(mif_data),
      .mif_addr_ff(mif_addr_ff), .xcvr_word_ff(xcvr_word_ff), .xcvr_addr_ff(xcvr_addr_ff),
      .xcvr_channel_ff(xcvr_channel_ff), .xcvr_write_ff(xcvr_write_ff), .pll_powerdown_ff(pll_powerdown_ff),
      .pll_ref_index_ff(pll_ref_index_ff), .tx_divider_ff(tx_divider_ff), .rx_divider_ff(rx_divider_ff),
      .divider_readback_ff(divider_readback_ff), .busy_ff(busy_ff), .done_ff(done_ff));
   tprc_mem_model mem_u (.mif_addr_ff(mif_addr_ff), .mif_data(mif_data));
   initial begin
      forever #50 clock = ~clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // One transaction; in step mode a strobe follows each write pulse but the last to release the next word.
   task automatic run(input logic [2:0] mode, input logic [1:0] ch, input int n, input logic cont);
      int k;
      logic [1:0] pd;
      k = 0;
      pd = (mode == 3'h4) ? (ch[0] ? 2'h2 : 2'h1) : 2'h0;
      @(negedge clock);
      mode_sel = mode;
      channel_index = ch;
      continuous_write = cont;
      write_strobe = 1'b1;
      for (int i = 0; i < 400; i++) begin
         @(negedge clock);
         if (xcvr_write_ff === 1'b1) begin
            chk(16'(xcvr_addr_ff), 16'(k));
            chk(xcvr_word_ff, {4'hc, 6'(k), ~6'(k)});
            chk(16'(xcvr_channel_ff), 16'(ch));
            k++;
         end
         write_strobe = !cont && xcvr_write_ff === 1'b1 && k < n;
         if (busy_ff === 1'b1) chk(16'(pll_powerdown_ff), 16'(pd));
         // No lock input here; the next request only follows completion.
         if (done_ff === 1'b1) begin
            chk(16'(k), 16'(n));
            chk(16'(pll_powerdown_ff), 16'h0000);
            return;
         end
      end
      n_fail++;
      summarize();
   endtask : run
   task automatic rate(input logic [1:0] ch, input logic [1:0] div);
      divider_select = div;
      if (div != `TPRC_DIV_UNUSED) exp_tx[2*ch +: 2] = div;
      run(3'h6, ch, 0, 1'b1);
      repeat (2) @(negedge clock);
      chk(16'(tx_divider_ff), 16'(exp_tx));
      chk(16'(rx_divider_ff), 16'h0000);
      chk(16'(divider_readback_ff), 16'(exp_tx[2*ch +: 2]));
   endtask : rate
   task automatic refused(input logic [2:0] mode, input logic pcie);
      @(negedge clock);
      mode_sel = mode;
      hard_ip_pcie_mode = pcie;
      write_strobe = 1'b1;
      repeat (6) begin
         @(negedge clock);
         write_strobe = 1'b0;
         chk(16'({busy_ff, done_ff, xcvr_write_ff}), 16'h0000);
      end
      hard_ip_pcie_mode = 1'b0;
   endtask : refused
   initial begin
      repeat (12) @(negedge clock);
      chk({pll_ref_index_ff, pll_powerdown_ff, divider_readback_ff, busy_ff, done_ff, 8'h00}, 16'h8000);
      chk({tx_divider_ff, rx_divider_ff}, 16'h0000);
      rstn = 1'b1;
      run(3'h4, 2'h1, `TPRC_WORDS_CMU_PLL, 1'b1);
      run(3'h4, 2'h2, `TPRC_WORDS_CMU_PLL, 1'b1);
      run(`TPRC_MODE_TXPLL_SEL, 2'h3, `TPRC_WORDS_TXPLL_SEL, 1'b0);
      run(`TPRC_MODE_CHAN_PLL, 2'h0, `TPRC_WORDS_CHAN_PLL, 1'b1);
      run(`TPRC_MODE_CCU, 2'h2, `TPRC_WORDS_CCU, 1'b1);
      rate(2'h1, `TPRC_DIV_BY4);
      rate(2'h1, `TPRC_DIV_BY2);
      rate(2'h2, `TPRC_DIV_BY1);
      rate(2'h1, `TPRC_DIV_UNUSED);
      refused(`TPRC_MODE_CMU_PLL, 1'b1);
      refused(3'h0, 1'b0);
      refused(3'h7, 1'b0);
      pll_index_first = 1'b1;
      repeat (2) @(negedge clock);
      chk(16'(pll_ref_index_ff), 16'h0001);
      summarize();
   end
endmodule : testbench
`default_nettype wire

// >>> tprc_consts.svh
`ifndef TPRC_CONSTS_SVH
`define TPRC_CONSTS_SVH
`define TPRC_MODE_CHAN_PLL 3'h1
`define TPRC_MODE_TXPLL_SEL 3'h2
`define TPRC_MODE_CMU_PLL 3'h4
`define TPRC_MODE_CCU 3'h5
`define TPRC_MODE_RATE_DIV 3'h6
`define TPRC_DIV_BY1 2'h0
`define TPRC_DIV_BY2 2'h1
`define TPRC_DIV_BY4 2'h2
`define TPRC_DIV_UNUSED 2'h3
`define TPRC_WORDS_CHAN_PLL 6'h37
`define TPRC_WORDS_TXPLL_SEL 6'h08
`define TPRC_WORDS_CMU_PLL 6'h08
`define TPRC_WORDS_CCU 6'h05
`define TPRC_WORD_WIDTH 16
`endif

// >>> tprc_mem_model.sv
`default_nettype none
module tprc_mem_model (
   input wire logic [5:0] mif_addr_ff,
   output logic [15:0] mif_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // Every address holds a different word, so an address slip shows up as a wrong word.
   assign mif_data = {4'hc, mif_addr_ff, ~mif_addr_ff};
endmodule : tprc_mem_model
`default_nettype wire

// >>> tprc_pkg.sv
`default_nettype none
package tprc_pkg;
   typedef enum logic [2:0] {
      TPRC_IDLE = 3'b000,
      TPRC_FETCH = 3'b001,
      TPRC_WRITE = 3'b010,
      TPRC_WAITSTB = 3'b011,
      TPRC_DONE = 3'b100
   } tprc_state_e;
endpackage : tprc_pkg
`default_nettype wire

// >>> tprc_top.sv
`include "tprc_consts.svh"
`default_nettype none
// Function
// - Only writes exist in transmit PLL select mode; no read path is provided.
// - PLL select mode reuses channel write sequence, different mode code and word count.
// - Continuous write option: one strobe transfers all words.
// - Completion pulse asserted after clock multiplier PLL reconfiguration finishes.
// - Selected PLL held powered down until reconfiguration completes, no external control.
// - Only the selected PLL is powered down; the other keeps running.
// - New PLL rate moves all channels clocked from it.
// - First PLL reference index is always the inverse of the second.
// - Bonded switch uses one word file, split between both steps.
// - Reconfiguration unavailable while hard protocol IP runs in PCI Express mode.
// - Rate division changes only the transmit local divider to 1, 2 or 4.
// - Receive dividers never change on a transmit rate division.
// - Divider readback uses the divider select encoding.
// - Rate division applies directly from divider select, no words transferred.
// - Divider select 10 means divide by four.
// - Readback returns 01 when divider is divide by two.
// - Every transferred word is 16 bits wide.
module tprc_top
   import tprc_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int CH_W = 2,
   parameter int ADDR_W = 6
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [2:0] mode_sel,
   input wire logic [CH_W-1:0] channel_index,
   input wire logic write_strobe,
   input wire logic continuous_write,
   input wire logic [1:0] divider_select,
   input wire logic hard_ip_pcie_mode,
   input wire logic pll_index_first,
   input wire logic [`TPRC_WORD_WIDTH-1:0] mif_data,
   output logic [ADDR_W-1:0] mif_addr_ff,
   output logic [`TPRC_WORD_WIDTH-1:0] xcvr_word_ff,
   output logic [ADDR_W-1:0] xcvr_addr_ff,
   output logic [CH_W-1:0] xcvr_channel_ff,
   output logic xcvr_write_ff,
   output logic [1:0] pll_powerdown_ff,
   output logic [1:0] pll_ref_index_ff,
   output logic [CHANNELS*2-1:0] tx_divider_ff,
   output logic [CHANNELS*2-1:0] rx_divider_ff,
   output logic [1:0] divider_readback_ff,
   output logic busy_ff,
   output logic done_ff
);
   // Only write transfers exist; the block has no read path in any word mode.
   tprc_state_e state_ff, nxt_state;
   logic [ADDR_W-1:0] nxt_mif_addr, last_ff, nxt_last;
   logic [`TPRC_WORD_WIDTH-1:0] nxt_word;
   logic [ADDR_W-1:0] nxt_xaddr;
   logic [CH_W-1:0] nxt_chan;
   logic nxt_write, nxt_busy, nxt_done, pll_sel_ff, nxt_pll_sel;
   logic [1:0] nxt_pd, nxt_rb, nxt_refi;
   logic [CHANNELS*2-1:0] nxt_txdiv;

   function automatic logic [ADDR_W-1:0] words_for(input logic [2:0] m);
      case (m)
         `TPRC_MODE_CHAN_PLL: words_for = ADDR_W'(`TPRC_WORDS_CHAN_PLL);
         `TPRC_MODE_TXPLL_SEL: words_for = ADDR_W'(`TPRC_WORDS_TXPLL_SEL);
         `TPRC_MODE_CMU_PLL: words_for = ADDR_W'(`TPRC_WORDS_CMU_PLL);
         `TPRC_MODE_CCU: words_for = ADDR_W'(`TPRC_WORDS_CCU);
         default: words_for = '0;
      endcase
   endfunction : words_for

   function automatic logic word_mode(input logic [2:0] m);
      word_mode = (words_for(m) != '0);
   endfunction : word_mode

   always_comb begin
      nxt_state = state_ff;
      nxt_mif_addr = mif_addr_ff;
      nxt_last = last_ff;
      nxt_word = xcvr_word_ff;
      nxt_xaddr = xcvr_addr_ff;
      nxt_chan = xcvr_channel_ff;
      nxt_write = 1'b0;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_pd = pll_powerdown_ff;
      nxt_pll_sel = pll_sel_ff;
      nxt_txdiv = tx_divider_ff;
      nxt_rb = tx_divider_ff[2*channel_index +: 2];
      // Reference indices always complement each other.
      nxt_refi = {~pll_index_first, pll_index_first};
      case (state_ff)
         TPRC_IDLE: begin
            // A strobe with the hard protocol IP in PCI Express mode is ignored.
            if (write_strobe && !hard_ip_pcie_mode) begin
               if (mode_sel == `TPRC_MODE_RATE_DIV) begin
                  // Divider 11 is unused and leaves the setting alone.
                  if (divider_select != `TPRC_DIV_UNUSED) begin
                     nxt_txdiv[2*channel_index +: 2] = divider_select;
                  end
                  nxt_done = 1'b1;
               end else if (word_mode(mode_sel)) begin
                  nxt_mif_addr = '0;
                  nxt_last = words_for(mode_sel) - ADDR_W'(1);
                  nxt_chan = channel_index;
                  nxt_busy = 1'b1;
                  nxt_state = TPRC_FETCH;
                  if (mode_sel == `TPRC_MODE_CMU_PLL) begin
                     nxt_pll_sel = channel_index[0];
                     nxt_pd[channel_index[0]] = 1'b1;
                  end
               end
            end
         end
         TPRC_FETCH: begin
            nxt_state = TPRC_WRITE;
         end
         TPRC_WRITE: begin
            nxt_word = mif_data;
            nxt_xaddr = mif_addr_ff;
            nxt_write = 1'b1;
            if (mif_addr_ff == last_ff) begin
               nxt_state = TPRC_DONE;
            end else begin
               nxt_mif_addr = mif_addr_ff + ADDR_W'(1);
               // Without continuous write each further word needs its own strobe.
               nxt_state = continuous_write ? TPRC_FETCH : TPRC_WAITSTB;
            end
         end
         TPRC_WAITSTB: begin
            if (write_strobe) begin
               nxt_state = TPRC_FETCH;
            end
         end
         TPRC_DONE: begin
            // Releasing power-down retunes every channel fed by this PLL.
            nxt_pd[pll_sel_ff] = 1'b0;
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_state = TPRC_IDLE;
         end
         default: begin
            nxt_state = TPRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_ff <= TPRC_IDLE;
         mif_addr_ff <= '0;
         last_ff <= '0;
         xcvr_word_ff <= '0;
         xcvr_addr_ff <= '0;
         xcvr_channel_ff <= '0;
         xcvr_write_ff <= 1'b0;
         pll_powerdown_ff <= 2'b00;
         pll_sel_ff <= 1'b0;
         pll_ref_index_ff <= 2'b10;
         tx_divider_ff <= '0;
         divider_readback_ff <= `TPRC_DIV_BY1;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mif_addr_ff <= nxt_mif_addr;
         last_ff <= nxt_last;
         xcvr_word_ff <= nxt_word;
         xcvr_addr_ff <= nxt_xaddr;
         xcvr_channel_ff <= nxt_chan;
         xcvr_write_ff <= nxt_write;
         pll_powerdown_ff <= nxt_pd;
         pll_sel_ff <= nxt_pll_sel;
         pll_ref_index_ff <= nxt_refi;
         tx_divider_ff <= nxt_txdiv;
         divider_readback_ff <= nxt_rb;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   // Receive dividers are never touched by this block.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rx_divider_ff <= '0;
      end else begin
         rx_divider_ff <= rx_divider_ff;
      end
   end

   sequence s_cmu_start;
      state_ff == TPRC_IDLE && write_strobe && !hard_ip_pcie_mode && mode_sel == `TPRC_MODE_CMU_PLL;
   endsequence

   a_pd_held: assert property (@(posedge clock) disable iff (!rstn)
      s_cmu_start |=> pll_powerdown_ff != 2'b00)
      else $error("PLL power-down not raised at start.");
   a_pd_keep: assert property (@(posedge clock) disable iff (!rstn)
      pll_powerdown_ff != 2'b00 && state_ff != TPRC_DONE |=> $stable(pll_powerdown_ff))
      else $error("PLL power-down dropped before completion.");
   a_pd_one: assert property (@(posedge clock) disable iff (!rstn)
      pll_powerdown_ff != 2'b11)
      else $error("Both PLLs powered down.");
   a_done_after: assert property (@(posedge clock) disable iff (!rstn)
      state_ff == TPRC_DONE |=> done_ff && !busy_ff && pll_powerdown_ff == 2'b00)
      else $error("Completion not reported.");
   a_cont_burst: assert property (@(posedge clock) disable iff (!rstn)
      state_ff == TPRC_WRITE && continuous_write && mif_addr_ff != last_ff |=> ##1 state_ff == TPRC_WRITE)
      else $error("Continuous write stalled.");
   a_ref_inv: assert property (@(posedge clock) disable iff (!rstn)
      pll_ref_index_ff[0] != pll_ref_index_ff[1])
      else $error("Reference indices not inverse.");
   a_pcie_block: assert property (@(posedge clock) disable iff (!rstn)
      state_ff == TPRC_IDLE && hard_ip_pcie_mode |=> state_ff == TPRC_IDLE && $stable(tx_divider_ff))
      else $error("Reconfiguration ran in PCI Express mode.");
   a_div_apply: assert property (@(posedge clock) disable iff (!rstn)
      state_ff == TPRC_IDLE && write_strobe && !hard_ip_pcie_mode && mode_sel == `TPRC_MODE_RATE_DIV
      && divider_select != `TPRC_DIV_UNUSED |=> tx_divider_ff[2*$past(channel_index) +: 2] == $past(divider_select)
      && done_ff && !xcvr_write_ff)
      else $error("Divider not applied directly.");
   a_rx_stable: assert property (@(posedge clock) disable iff (!rstn)
      ##1 $stable(rx_divider_ff))
      else $error("Receive divider changed.");
   a_readback: assert property (@(posedge clock) disable iff (!rstn)
      ##1 divider_readback_ff == $past(tx_divider_ff[2*channel_index +: 2]))
      else $error("Readback encoding mismatch.");
endmodule : tprc_top
`default_nettype wire
